// *** verilog/isr_params.svh ***
// register offsets, field positions, command codes and reset values of the status block
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH

`define OFS_RECEIVE_QUEUE 8'h03
`define OFS_COMMAND_REG 8'h02
`define OFS_MASK_REG 8'h24
`define OFS_STATUS_REG 8'h25
`define OFS_INPUT_PORT 8'h26
`define OFS_FLOW_STATUS 8'h27
`define OFS_ADDR_MATCH 8'h28
`define OFS_RX_LEVEL 8'h29
`define OFS_GLOBAL_CONFIG 8'h30
`define OFS_GLOBAL_RX_QUEUE 8'h40

`define BIT_PORT_CHANGE 7
`define BIT_WATCHDOG 6
`define BIT_ADDR_MATCH 5
`define BIT_FLOW_CHAR 4
`define BIT_COUNTER 3
`define BIT_BREAK 2
`define BIT_RX_LEVEL 1
`define BIT_TX_ARB 0
`define CFG_READ_MASK 0

`define CMD_RST_ADDR_MATCH 5'h1B
`define CMD_RST_BREAK 5'h05
`define CMD_STOP_COUNTER 5'h0F

`define RST_MASK 8'h00
`define RST_CONFIG 8'h00
`define RST_ADDR_CHAR 8'h00
`define RST_RX_LEVEL 8'h01
`define WDG_BIT_TIMES 64

`endif

// *** verilog/isr_pkg.sv ***
// shared types of the interrupt status block
package isr_pkg;
   typedef logic [7:0] reg8_t;
   typedef logic [4:0] cmd_t;
endpackage

// *** verilog/wdg_if.sv ***
// link between the status block and its receive watchdog
`timescale 1ns/1ps
interface wdg_if;
   logic tick;
   logic kick;
   logic timeout;
   modport ctrl (output tick, output kick, input timeout);
   modport wdg (input tick, input kick, output timeout);
endinterface

// *** verilog/pin_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// *** verilog/rx_watchdog.sv ***
// receive watchdog: one pulse after more than LIMIT bit times with no queue event
`timescale 1ns/1ps
`include "isr_params.svh"
module rx_watchdog #(
   parameter int LIMIT = `WDG_BIT_TIMES
) (
   input wire logic clk,
   input wire logic sys_rst,
   wdg_if.wdg link
);
   localparam int CW = $clog2(LIMIT + 2);
   logic [CW-1:0] cnt_r;
   logic fired_r;

   // count bit times; a kick restarts, one time-out per quiet spell
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= '0;
         fired_r <= 1'b0;
      end else if (link.kick) begin
         cnt_r <= '0;
         fired_r <= 1'b0;
      end else if (link.tick && !fired_r) begin
         cnt_r <= cnt_r + CW'(1);
         if (cnt_r == CW'(LIMIT)) begin
            fired_r <= 1'b1;
         end
      end
   end

   // pulse on the tick that makes the count exceed the limit
   assign link.timeout = link.tick && !link.kick && !fired_r && (cnt_r == CW'(LIMIT));
endmodule

// *** verilog/uart_interrupt_status_sources.sv ***
// interrupt status collection, masking and request for one serial channel
`timescale 1ns/1ps
`include "isr_params.svh"

module uart_interrupt_status_sources #(
   parameter int FILL_W = 9,
   parameter int WDG_LIMIT = `WDG_BIT_TIMES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire isr_pkg::reg8_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output isr_pkg::reg8_t reg_rdata,
   input wire logic [1:0] io_pin_in,
   input wire isr_pkg::reg8_t rx_queue_data,
   input wire logic rx_char_load,
   input wire logic rx_bit_tick,
   input wire logic [FILL_W-1:0] rx_fill_level,
   input wire logic rx_addr_valid,
   input wire isr_pkg::reg8_t rx_addr_char,
   input wire logic flow_char_rcvd,
   input wire logic counter_expired,
   input wire logic break_change,
   input wire logic tx_arb_active,
   output logic rx_queue_pop,
   output logic counter_stop,
   output logic interrupt_request_n,
   output logic tx_dma_handshake
);
   import isr_pkg::*;

   reg8_t isr_r;
   reg8_t interrupt_mask_reg_r;
   reg8_t global_chip_config_r;
   reg8_t address_match_char_r;
   reg8_t rx_level_r;
   reg8_t set_vec;
   reg8_t clr_vec;
   logic [1:0] io_sync;
   logic [1:0] io_prev_r;
   logic port_change;
   logic rd_status;
   logic rd_ipr;
   logic rd_flow;
   logic rd_queue;
   logic wr_cmd;
   cmd_t cmd;
   logic addr_hit;
   logic rx_level_hit;
   logic [FILL_W-1:0] threshold;
   wdg_if wlink ();

   // pins cross into the clock domain before anyone looks at them
   pin_sync #(.WIDTH(2)) u_pin_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(io_pin_in),
      .sync_out(io_sync)
   );

   rx_watchdog #(.LIMIT(WDG_LIMIT)) u_rx_watchdog (
      .clk(clk),
      .sys_rst(sys_rst),
      .link(wlink.wdg)
   );

   // access decode
   assign rd_status = reg_rd && (reg_addr == `OFS_STATUS_REG);
   assign rd_ipr = reg_rd && (reg_addr == `OFS_INPUT_PORT);
   assign rd_flow = reg_rd && (reg_addr == `OFS_FLOW_STATUS);
   assign rd_queue = reg_rd && ((reg_addr == `OFS_RECEIVE_QUEUE) ||
                                (reg_addr == `OFS_GLOBAL_RX_QUEUE));
   assign wr_cmd = reg_wr && (reg_addr == `OFS_COMMAND_REG);
   assign cmd = reg_wdata[4:0];

   // watchdog restarts on any queue event
   assign wlink.tick = rx_bit_tick;
   assign wlink.kick = rd_queue || rx_char_load;

   // edge detect on the second synchroniser stage only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         io_prev_r <= 2'h0;
      end else begin
         io_prev_r <= io_sync;
      end
   end
   assign port_change = |(io_sync ^ io_prev_r);

   assign addr_hit = rx_addr_valid && (rx_addr_char == address_match_char_r);

   // event sources of the sticky bits
   always_comb begin
      set_vec = 8'h00;
      set_vec[`BIT_PORT_CHANGE] = port_change;
      set_vec[`BIT_WATCHDOG] = wlink.timeout;
      set_vec[`BIT_ADDR_MATCH] = addr_hit;
      set_vec[`BIT_FLOW_CHAR] = flow_char_rcvd;
      set_vec[`BIT_COUNTER] = counter_expired;
      set_vec[`BIT_BREAK] = break_change;
   end

   // clearing actions; the counter bit waits for its stop command only
   always_comb begin
      clr_vec = 8'h00;
      clr_vec[`BIT_PORT_CHANGE] = rd_ipr;
      clr_vec[`BIT_WATCHDOG] = rd_queue;
      clr_vec[`BIT_ADDR_MATCH] = wr_cmd && (cmd == `CMD_RST_ADDR_MATCH);
      clr_vec[`BIT_FLOW_CHAR] = rd_flow;
      clr_vec[`BIT_COUNTER] = wr_cmd && (cmd == `CMD_STOP_COUNTER);
      clr_vec[`BIT_BREAK] = wr_cmd && (cmd == `CMD_RST_BREAK);
   end

   // sticky bits; set first so an event in a clear cycle survives
   genvar gi;
   generate
      for (gi = `BIT_BREAK; gi <= `BIT_PORT_CHANGE; gi++) begin : g_sticky
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               isr_r[gi] <= 1'b0;
            end else if (set_vec[gi]) begin
               isr_r[gi] <= 1'b1;
            end else if (clr_vec[gi]) begin
               isr_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // a zero threshold still needs one character, so empty never requests
   assign threshold = {{(FILL_W-8){1'b0}}, rx_level_r};
   assign rx_level_hit = (rx_fill_level >= threshold) && (rx_fill_level != '0);

   // live level bits follow their sources one cycle behind
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         isr_r[`BIT_RX_LEVEL] <= 1'b0;
         isr_r[`BIT_TX_ARB] <= 1'b0;
      end else begin
         isr_r[`BIT_RX_LEVEL] <= rx_level_hit;
         isr_r[`BIT_TX_ARB] <= tx_arb_active;
      end
   end

   // writable control registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         interrupt_mask_reg_r <= `RST_MASK;
         global_chip_config_r <= `RST_CONFIG;
         address_match_char_r <= `RST_ADDR_CHAR;
         rx_level_r <= `RST_RX_LEVEL;
      end else if (reg_wr) begin
         case (reg_addr)
            `OFS_MASK_REG: interrupt_mask_reg_r <= reg_wdata;
            `OFS_GLOBAL_CONFIG: global_chip_config_r <= reg_wdata;
            `OFS_ADDR_MATCH: address_match_char_r <= reg_wdata;
            `OFS_RX_LEVEL: rx_level_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read data live for exactly the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_STATUS_REG: begin
               if (global_chip_config_r[`CFG_READ_MASK]) begin
                  reg_rdata <= isr_r & interrupt_mask_reg_r;
               end else begin
                  reg_rdata <= isr_r;
               end
            end
            `OFS_MASK_REG: reg_rdata <= interrupt_mask_reg_r;
            `OFS_GLOBAL_CONFIG: reg_rdata <= global_chip_config_r;
            `OFS_ADDR_MATCH: reg_rdata <= address_match_char_r;
            `OFS_RX_LEVEL: reg_rdata <= rx_level_r;
            `OFS_INPUT_PORT: reg_rdata <= {6'h00, io_sync};
            `OFS_FLOW_STATUS: reg_rdata <= {7'h00, isr_r[`BIT_FLOW_CHAR]};
            `OFS_RECEIVE_QUEUE: reg_rdata <= rx_queue_data;
            `OFS_GLOBAL_RX_QUEUE: reg_rdata <= rx_queue_data;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // request is registered, so it trails the status by one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         interrupt_request_n <= 1'b1;
      end else begin
         interrupt_request_n <= ~|(isr_r & interrupt_mask_reg_r);
      end
   end

   // side outputs toward the queue, counter and handshake pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_queue_pop <= 1'b0;
         counter_stop <= 1'b0;
         tx_dma_handshake <= 1'b0;
      end else begin
         rx_queue_pop <= rd_queue;
         counter_stop <= clr_vec[`BIT_COUNTER];
         tx_dma_handshake <= isr_r[`BIT_TX_ARB];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_addr_hit;
      rx_addr_valid && (rx_addr_char == address_match_char_r);
   endsequence
   sequence s_addr_clear;
      wr_cmd && (cmd == `CMD_RST_ADDR_MATCH) && !addr_hit;
   endsequence
   sequence s_break_clear;
      wr_cmd && (cmd == `CMD_RST_BREAK) && !break_change;
   endsequence

   a_mask_gates_irq: assert property (
      (isr_r & interrupt_mask_reg_r) == 8'h00 |=> interrupt_request_n)
      else $error("request raised with no unmasked source");
   a_masked_source_irq: assert property (
      (isr_r & interrupt_mask_reg_r) != 8'h00 |=> !interrupt_request_n)
      else $error("unmasked source did not raise request");
   a_raw_status_read: assert property (
      rd_status && !global_chip_config_r[`CFG_READ_MASK] |=> reg_rdata == $past(isr_r))
      else $error("raw status read wrong");
   a_masked_status_read: assert property (
      rd_status && global_chip_config_r[`CFG_READ_MASK]
      |=> reg_rdata == ($past(isr_r) & $past(interrupt_mask_reg_r)))
      else $error("masked status read wrong");
   a_port_change_set: assert property (
      $changed(io_sync) |=> isr_r[`BIT_PORT_CHANGE])
      else $error("port change not flagged");
   a_port_read_clear: assert property (
      rd_ipr && !port_change |=> !isr_r[`BIT_PORT_CHANGE])
      else $error("input port read did not clear bit 7");
   a_watchdog_set: assert property (
      wlink.timeout |=> isr_r[`BIT_WATCHDOG])
      else $error("watchdog time-out not flagged");
   a_queue_read_clear: assert property (
      rd_queue && !wlink.timeout |=> !isr_r[`BIT_WATCHDOG] && rx_queue_pop)
      else $error("queue read did not clear bit 6");
   a_addr_match_flow: assert property (
      s_addr_hit |=> isr_r[`BIT_ADDR_MATCH])
      else $error("address match set failed");
   a_addr_cmd_clear: assert property (
      s_addr_clear |=> !isr_r[`BIT_ADDR_MATCH])
      else $error("address match command did not clear bit 5");
   a_flow_read_clear: assert property (
      rd_flow && !flow_char_rcvd |=> !isr_r[`BIT_FLOW_CHAR])
      else $error("flow status read did not clear bit 4");
   a_counter_holds: assert property (
      isr_r[`BIT_COUNTER] && !(wr_cmd && (cmd == `CMD_STOP_COUNTER)) |=> isr_r[`BIT_COUNTER])
      else $error("counter bit dropped without stop command");
   a_break_clear: assert property (
      s_break_clear |=> !isr_r[`BIT_BREAK])
      else $error("break command did not clear bit 2");
   a_rx_level_track: assert property (
      1'b1 |=> isr_r[`BIT_RX_LEVEL] == $past(rx_level_hit) && !(isr_r[`BIT_RX_LEVEL] &&
      $past(rx_fill_level) == '0))
      else $error("receive level bit wrong");
   a_tx_handshake: assert property (
      isr_r[`BIT_TX_ARB] |=> tx_dma_handshake)
      else $error("transmit handshake does not follow bit 0");
   a_flow_char_set: assert property (
      flow_char_rcvd |=> isr_r[`BIT_FLOW_CHAR])
      else $error("flow character not flagged");
   a_counter_set: assert property (
      counter_expired |=> isr_r[`BIT_COUNTER])
      else $error("counter expiry not flagged");
   a_break_set: assert property (
      break_change |=> isr_r[`BIT_BREAK])
      else $error("break change not flagged");
   a_set_beats_clear: assert property (
      (set_vec & clr_vec) != 8'h00
      |=> (isr_r & $past(set_vec & clr_vec)) == $past(set_vec & clr_vec))
      else $error("clear beat a simultaneous set");
endmodule

// *** sim/host_cpu_model.sv ***
// host processor model: master of the register port of the status block
`timescale 1ns/1ps
module host_cpu_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output isr_pkg::reg8_t reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire isr_pkg::reg8_t reg_rdata
);
   import isr_pkg::*;

   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // one-cycle write; released lines show the inverse so stale values never match
   task automatic wr(input logic [7:0] a, input reg8_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // one-cycle read; data taken in the cycle after the strobe only
   task automatic rd(input logic [7:0] a, output reg8_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

// *** sim/uart_interrupt_status_sources_tb.sv ***
// self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "isr_params.svh"
module uart_interrupt_status_sources_tb;
   import isr_pkg::*;
   localparam int WDG = 4;
   logic clk, sys_rst, reg_wr, reg_rd, rx_char_load, rx_bit_tick, rx_addr_valid;
   logic flow_char_rcvd, counter_expired, break_change, tx_arb_active;
   logic rx_queue_pop, counter_stop, interrupt_request_n, tx_dma_handshake;
   logic [7:0] reg_addr;
   logic [1:0] io_pin_in;
   logic [8:0] rx_fill_level;
   reg8_t reg_wdata, reg_rdata, rx_queue_data, rx_addr_char, d;
   int errors = 0;
   int comparisons = 0;

   uart_interrupt_status_sources #(.FILL_W(9), .WDG_LIMIT(WDG)) u_uart_interrupt_status_sources (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_pin_in(io_pin_in),
      .rx_queue_data(rx_queue_data), .rx_char_load(rx_char_load), .rx_bit_tick(rx_bit_tick),
      .rx_fill_level(rx_fill_level), .rx_addr_valid(rx_addr_valid),
      .rx_addr_char(rx_addr_char), .flow_char_rcvd(flow_char_rcvd),
      .counter_expired(counter_expired), .break_change(break_change),
      .tx_arb_active(tx_arb_active), .rx_queue_pop(rx_queue_pop),
      .counter_stop(counter_stop), .interrupt_request_n(interrupt_request_n),
      .tx_dma_handshake(tx_dma_handshake));

   host_cpu_model u_host_cpu_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input reg8_t got, input reg8_t exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read the status register and compare
   task automatic st(input reg8_t exp);
      reg8_t v;
      u_host_cpu_model.rd(`OFS_STATUS_REG, v);
      chk(v, exp);
   endtask

   task automatic rdc(input logic [7:0] a, input reg8_t exp);
      reg8_t v;
      u_host_cpu_model.rd(a, v);
      chk(v, exp);
   endtask

   task automatic wr(input logic [7:0] a, input reg8_t v);
      u_host_cpu_model.wr(a, v);
   endtask

   // one-cycle event pulse, then room for the sticky bit and the request to land
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: break_change <= 1'b1;
         1: flow_char_rcvd <= 1'b1;
         2: counter_expired <= 1'b1;
         default: rx_char_load <= 1'b1;
      endcase
      @(posedge clk);
      break_change <= 1'b0;
      flow_char_rcvd <= 1'b0;
      counter_expired <= 1'b0;
      rx_char_load <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic addr_ev(input reg8_t c);
      @(posedge clk);
      rx_addr_char <= c;
      rx_addr_valid <= 1'b1;
      @(posedge clk);
      rx_addr_valid <= 1'b0;
      rx_addr_char <= ~c;
      repeat (2) @(posedge clk);
   endtask

   task automatic ticks(input int n);
      @(posedge clk);
      rx_bit_tick <= 1'b1;
      repeat (n) @(posedge clk);
      rx_bit_tick <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // reset values, read-only status, unmapped address
   task automatic t_reset();
      st(8'h00);
      rdc(`OFS_MASK_REG, `RST_MASK);
      rdc(`OFS_RX_LEVEL, `RST_RX_LEVEL);
      rdc(8'h7F, 8'h00);
      wr(`OFS_STATUS_REG, 8'hFF);
      st(8'h00);
      chk({7'h00, interrupt_request_n}, 8'h01);
   endtask

   task automatic t_break();
      wr(`OFS_MASK_REG, 8'h04);
      pulse(0);
      chk({7'h00, interrupt_request_n}, 8'h00);
      st(8'h04);
      wr(`OFS_COMMAND_REG, 8'h05);
      repeat (2) @(posedge clk);
      chk({7'h00, interrupt_request_n}, 8'h01);
      st(8'h00);
   endtask

   // masked-out source never requests; masked read
   task automatic t_flow();
      pulse(1);
      chk({7'h00, interrupt_request_n}, 8'h01);
      st(8'h10);
      wr(`OFS_GLOBAL_CONFIG, 8'h01);
      st(8'h00);
      pulse(0);
      st(8'h04);
      wr(`OFS_GLOBAL_CONFIG, 8'h00);
      wr(`OFS_COMMAND_REG, 8'h05);
      rdc(`OFS_FLOW_STATUS, 8'h01);
      st(8'h00);
   endtask

   task automatic t_addr();
      wr(`OFS_ADDR_MATCH, 8'h5A);
      addr_ev(8'h33);
      st(8'h00);
      addr_ev(8'h5A);
      st(8'h20);
      wr(`OFS_COMMAND_REG, 8'h3B);
      st(8'h00);
   endtask

   task automatic t_counter();
      pulse(2);
      st(8'h08);
      st(8'h08);
      wr(`OFS_COMMAND_REG, 8'h0F);
      #1;
      chk({7'h00, counter_stop}, 8'h01);
      st(8'h00);
   endtask

   task automatic t_pins();
      @(posedge clk);
      io_pin_in <= 2'b10;
      repeat (5) @(posedge clk);
      st(8'h80);
      rdc(`OFS_INPUT_PORT, 8'h02);
      st(8'h00);
   endtask

   // quiet spells with and without a character load, then both queue reads
   task automatic t_wdg();
      logic [7:0] q[2];
      q[0] = `OFS_RECEIVE_QUEUE;
      q[1] = `OFS_GLOBAL_RX_QUEUE;
      u_host_cpu_model.rd(`OFS_GLOBAL_RX_QUEUE, d);
      ticks(WDG);
      st(8'h00);
      pulse(3);
      ticks(WDG);
      st(8'h00);
      for (int i = 0; i < 2; i++) begin
         ticks(1 + WDG * (1 - i) + i * (WDG + 1));
         st(8'h40);
         u_host_cpu_model.rd(q[i], d);
         chk({7'h00, rx_queue_pop}, 8'h01);
         if (i == 0) begin
            chk(d, rx_queue_data);
         end
         st(8'h00);
      end
   endtask

   task automatic t_levels();
      st(8'h00);
      @(posedge clk);
      rx_fill_level <= 9'h001;
      repeat (2) @(posedge clk);
      st(8'h02);
      wr(`OFS_RX_LEVEL, 8'h03);
      rx_fill_level <= 9'h002;
      st(8'h00);
      @(posedge clk);
      rx_fill_level <= 9'h003;
      st(8'h02);
      @(posedge clk);
      rx_fill_level <= 9'h000;
      tx_arb_active <= 1'b1;
      repeat (3) @(posedge clk);
      st(8'h01);
      chk({7'h00, tx_dma_handshake}, 8'h01);
      tx_arb_active <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // set and clear in one cycle: the set survives
   task automatic t_race();
      fork
         wr(`OFS_COMMAND_REG, 8'h05);
         begin
            @(posedge clk);
            break_change <= 1'b1;
            @(posedge clk);
            break_change <= 1'b0;
         end
      join
      repeat (2) @(posedge clk);
      st(8'h04);
      wr(`OFS_COMMAND_REG, 8'h05);
      st(8'h00);
   endtask

   task automatic final_report();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // watchdog against a hang; the tests need well under 2000 cycles
   initial begin
      #200000;
      errors++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      {rx_char_load, rx_bit_tick, rx_addr_valid, flow_char_rcvd} = 4'h0;
      {counter_expired, break_change, tx_arb_active} = 3'h0;
      io_pin_in = 2'b00;
      rx_fill_level = 9'h000;
      rx_queue_data = 8'hC3;
      rx_addr_char = 8'h00;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_break();
      t_flow();
      t_addr();
      t_counter();
      t_pins();
      t_wdg();
      t_levels();
      t_race();
      final_report();
   end
endmodule
